// file: logic/umfs_top.sv
// UART channel with mode register two, flow control, stop length and loop modes.
//
// Operation
// (R1) Mode register two is reached only via pointer; first-register access moves pointer there.
// (R2) Bits 7-6 pick normal, automatic echo, local loop-back or remote loop-back.
// (R3) With bit 5 set, request-to-send negates one bit after transmitter drains.
// (R4) Request-to-send control on both receiver and transmitter disables it for both.
// (R5) With bit 4 set, each character waits for clear-to-send; line idles high.
// (R6) Clear-to-send changes during a character do not disturb that character.
// (R7) With both bits 4 and 5 set, clear-to-send gating governs the transmitter.
// (R8) Stop length 9/16 to 2 bits, or 1-1/16 to 2 for 5-bit characters.
// (R9) Code 0000 gives 1.063 or 0.563 bits; code 1000 1.563; steps of 1/16.
// (R10) Code 0111 gives 1.500 or 1.000 bits; code 1111 gives 2.000 bits.
// (R11) Receiver checks only for high at centre of first stop bit.
// (R12) With external 1x clock, stop-length bit 3 picks one or two stop bits.
`timescale 1ns/1ns
module umfs_top
  import umfs_pkg::*;
#(
  parameter logic [7:0] TICK_DIV = UMFS_TICK_DIV_DEF
)
(
  input  logic          clk_sys_i,
  input  logic          reset_n_i,
  input  umfs_bus_req_t bus_i,
  output logic [7:0]    rdata_o,
  input  logic          rxd_i,
  input  logic          clear_to_send_in_n_i,
  input  logic          tx_ext_clk_i,
  output logic          serial_transmit_line_o,
  output logic          request_to_send_out_n_o
);

  umfs_state_t st;
  umfs_state_t n;

  logic       tick16;
  logic       xrise;
  logic       tx_tick;
  logic       five_bit;
  logic       auto_rts;
  logic       tx_par;
  logic       rx_in;
  logic       bit_end;
  logic       stop_end;
  logic [3:0] nbits;
  logic [5:0] bit_len;
  logic [5:0] stop_len;
  logic [7:0] data_mask;

  assign tick16    = (st.div == (TICK_DIV - 8'h01));
  assign xrise     = st.xclk_s & ~st.xclk_d;
  assign tx_tick   = st.ext_clk ? xrise : tick16;
  assign nbits     = UMFS_MIN_BITS + {2'b00, st.mode1[1:0]};
  assign five_bit  = (st.mode1[1:0] == 2'b00);
  assign bit_len   = st.ext_clk ? UMFS_EXT_BIT_LEN : UMFS_BIT_SIXTEENTHS;
  assign data_mask = ~(8'hff << nbits);
  assign tx_par    = ^(st.tx_shift & data_mask);
  assign bit_end   = tx_tick && (st.tx_cnt == (bit_len - 6'h01));
  assign stop_end  = tx_tick && (st.tx_cnt == (stop_len - 6'h01));
  // Short codes of longer characters start at 9/16; 5-bit characters start at 17/16.
  assign stop_len  = st.ext_clk ? (st.mode2.sb[3] ? UMFS_EXT_STOP_TWO : UMFS_EXT_STOP_ONE) // [R12]
                   : (((st.mode2.sb[3] | five_bit) ? UMFS_STOP_BASE_LONG : UMFS_STOP_BASE_SHRT)
                      + {2'b00, st.mode2.sb}); // [R8] [R9] [R10]
  // Automatic negation is off when the receiver also claims it or gating is on.
  assign auto_rts  = st.mode2.tx_rts & ~st.mode1[UMFS_M1_RX_RTS] & ~st.mode2.tx_cts; // [R4] [R7]
  assign rx_in     = (st.mode2.cm == UMFS_CM_LOCAL)  ? st.tx_line :
                     (st.mode2.cm == UMFS_CM_REMOTE) ? 1'b1 : st.rxd_s; // [R2]

  always_comb
  begin
    n          = st;
    n.rdata    = 8'h00;
    n.rxd_m    = rxd_i;
    n.rxd_s    = st.rxd_m;
    n.cts_m    = clear_to_send_in_n_i;
    n.cts_n_s  = st.cts_m;
    n.xclk_m   = tx_ext_clk_i;
    n.xclk_s   = st.xclk_m;
    n.xclk_d   = st.xclk_s;
    n.div      = tick16 ? 8'h00 : (st.div + 8'h01);

    // Transmitter.
    case (st.tx)
      UMFS_TX_IDLE:
      begin
        n.tx_line = 1'b1;
        // Under the 1x clock a character starts only on a clock edge, so its start bit is whole.
        if (st.hold_full && !(st.mode2.tx_cts && st.cts_n_s) && (!st.ext_clk || xrise)) // [R5]
        begin
          n.tx_shift  = st.hold;
          n.hold_full = 1'b0;
          n.tx_cnt    = 6'h00;
          n.tx        = UMFS_TX_START;
          n.tx_line   = 1'b0;
        end
      end
      UMFS_TX_START, UMFS_TX_DATA, UMFS_TX_PAR:
      begin
        // Clear-to-send is not looked at once the start bit is out.
        n.tx_cnt = tx_tick ? (st.tx_cnt + 6'h01) : st.tx_cnt; // [R6]
        if (bit_end)
        begin
          n.tx_cnt = 6'h00;
          if (st.tx == UMFS_TX_START)
          begin
            n.tx      = UMFS_TX_DATA;
            n.tx_idx  = 4'h0;
            n.tx_line = st.tx_shift[0];
          end
          else if ((st.tx == UMFS_TX_DATA) && (st.tx_idx != (nbits - 4'h1)))
          begin
            n.tx_idx  = st.tx_idx + 4'h1;
            n.tx_line = st.tx_shift[3'(st.tx_idx + 4'h1)];
          end
          else if ((st.tx == UMFS_TX_DATA) && st.mode1[UMFS_M1_PAR_EN])
          begin
            n.tx      = UMFS_TX_PAR;
            n.tx_line = tx_par;
          end
          else
          begin
            n.tx      = UMFS_TX_STOP;
            n.tx_line = 1'b1;
          end
        end
      end
      UMFS_TX_STOP:
      begin
        n.tx_line = 1'b1;
        n.tx_cnt  = tx_tick ? (st.tx_cnt + 6'h01) : st.tx_cnt;
        if (stop_end)
        begin
          n.tx_cnt = 6'h00;
          n.tx     = (!st.hold_full && auto_rts) ? UMFS_TX_RTSD : UMFS_TX_IDLE; // [R3]
          // The 1x clock edge that ends the stop bits also starts a waiting character.
          if (st.ext_clk && st.hold_full && !(st.mode2.tx_cts && st.cts_n_s)) // [R5] [R12]
          begin
            n.tx_shift  = st.hold;
            n.hold_full = 1'b0;
            n.tx        = UMFS_TX_START;
            n.tx_line   = 1'b0;
          end
        end
      end
      UMFS_TX_RTSD:
      begin
        n.tx_line = 1'b1;
        n.tx_cnt  = tx_tick ? (st.tx_cnt + 6'h01) : st.tx_cnt;
        if (st.hold_full)
        begin
          n.tx = UMFS_TX_IDLE;
        end
        else if (bit_end)
        begin
          n.rts_n = 1'b1; // [R3]
          n.tx    = UMFS_TX_IDLE;
        end
      end
      default:
      begin
        n.tx      = UMFS_TX_IDLE;
        n.tx_line = 1'b1;
      end
    endcase

    // Register port; a software write to the holding register wins over a load.
    if (bus_i.wr)
    begin
      case (bus_i.addr)
        UMFS_ADDR_MODE:
        begin
          if (st.ptr_mode2)
          begin
            n.mode2 = umfs_mode2_t'(bus_i.wdata); // [R1]
          end
          else
          begin
            n.mode1     = bus_i.wdata;
            n.ptr_mode2 = 1'b1; // [R1]
          end
        end
        UMFS_ADDR_DATA:
        begin
          n.hold      = bus_i.wdata;
          n.hold_full = 1'b1;
        end
        UMFS_ADDR_CTRL:
        begin
          n.ext_clk = bus_i.wdata[UMFS_CTRL_EXT_CLK];
          if (bus_i.wdata[UMFS_CTRL_PTR_RST])
          begin
            n.ptr_mode2 = 1'b0;
          end
          if (bus_i.wdata[UMFS_CTRL_RTS_ON])
          begin
            n.rts_n = 1'b0;
          end
          else if (bus_i.wdata[UMFS_CTRL_RTS_OFF])
          begin
            n.rts_n = 1'b1;
          end
        end
        default:
        begin
        end
      endcase
    end
    if (bus_i.rd)
    begin
      case (bus_i.addr)
        UMFS_ADDR_MODE:
        begin
          n.rdata     = st.ptr_mode2 ? 8'(st.mode2) : st.mode1; // [R1]
          n.ptr_mode2 = 1'b1;
        end
        UMFS_ADDR_STATUS:
        begin
          n.rdata[UMFS_ST_TX_RDY] = ~st.hold_full;
          n.rdata[UMFS_ST_TX_EMP] = ~st.hold_full && (st.tx == UMFS_TX_IDLE);
          n.rdata[UMFS_ST_RX_RDY] = st.rx_ready;
          n.rdata[UMFS_ST_FE]     = st.rx_fe;
          n.rdata[UMFS_ST_RTS]    = ~st.rts_n;
          n.rdata[UMFS_ST_PTR]    = st.ptr_mode2;
        end
        UMFS_ADDR_DATA:
        begin
          n.rdata    = st.rx_data;
          n.rx_ready = 1'b0;
        end
        default:
        begin
          n.rdata = 8'h00;
        end
      endcase
    end

    // Receiver; a frame completing in a read cycle keeps its ready flag set.
    n.rx_cnt = tick16 ? (st.rx_cnt + 4'h1) : st.rx_cnt;
    case (st.rx)
      UMFS_RX_IDLE:
      begin
        n.rx_cnt = 4'h0;
        if (!rx_in)
        begin
          n.rx = UMFS_RX_START;
        end
      end
      UMFS_RX_START:
      begin
        if (tick16 && (st.rx_cnt == UMFS_RX_HALF))
        begin
          n.rx_cnt = 4'h0;
          n.rx_idx = 4'h0;
          n.rx     = rx_in ? UMFS_RX_IDLE : UMFS_RX_BITS;
        end
      end
      UMFS_RX_BITS:
      begin
        if (tick16 && (st.rx_cnt == UMFS_RX_LAST))
        begin
          if (st.rx_idx < nbits)
          begin
            n.rx_shift[3'(st.rx_idx)] = rx_in;
          end
          n.rx_idx = st.rx_idx + 4'h1;
          if (st.rx_idx == (nbits - {3'b000, ~st.mode1[UMFS_M1_PAR_EN]}))
          begin
            n.rx = UMFS_RX_STOP;
          end
        end
      end
      UMFS_RX_STOP:
      begin
        if (tick16 && (st.rx_cnt == UMFS_RX_LAST))
        begin
          n.rx_fe    = ~rx_in; // [R11]
          n.rx_data  = st.rx_shift & data_mask;
          n.rx_ready = 1'b1;
          n.rx       = UMFS_RX_IDLE;
        end
      end
      default:
      begin
        n.rx = UMFS_RX_IDLE;
      end
    endcase

    case (st.mode2.cm)
      UMFS_CM_NORMAL: n.serial = n.tx_line;
      UMFS_CM_LOCAL:  n.serial = 1'b1;
      default:        n.serial = st.rxd_s; // [R2]
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st         <= '0;
      st.mode1   <= UMFS_MODE1_RST;
      st.mode2   <= umfs_mode2_t'(UMFS_MODE2_RST);
      st.rxd_m   <= 1'b1;
      st.rxd_s   <= 1'b1;
      st.cts_m   <= 1'b1;
      st.cts_n_s <= 1'b1;
      st.tx_line <= 1'b1;
      st.serial  <= 1'b1;
      st.rts_n   <= 1'b1;
    end
    else
    begin
      st <= n;
    end
  end

  assign rdata_o                 = st.rdata;
  assign serial_transmit_line_o  = st.serial;
  assign request_to_send_out_n_o = st.rts_n;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  ptr_moves_a: assert property ((bus_i.rd || bus_i.wr) && bus_i.addr == UMFS_ADDR_MODE // [R1]
    && !(bus_i.wr && bus_i.addr == UMFS_ADDR_CTRL) |=> st.ptr_mode2)
    else $error("pointer did not select mode register two");
  mode2_write_a: assert property (bus_i.wr && bus_i.addr == UMFS_ADDR_MODE && st.ptr_mode2 // [R1]
    |=> 8'(st.mode2) == $past(bus_i.wdata) && st.mode1 == $past(st.mode1))
    else $error("mode register two write went astray");
  echo_line_a: assert property (st.mode2.cm == UMFS_CM_ECHO // [R2]
    |=> serial_transmit_line_o == $past(st.rxd_s))
    else $error("echo mode does not copy the receive line");
  local_line_a: assert property (st.mode2.cm == UMFS_CM_LOCAL |=> serial_transmit_line_o) // [R2]
    else $error("local loop-back does not hold the line high");
  rts_negate_a: assert property (st.tx == UMFS_TX_RTSD && bit_end && !st.hold_full // [R3]
    && !(bus_i.wr && bus_i.addr == UMFS_ADDR_CTRL)
    |=> request_to_send_out_n_o && st.tx == UMFS_TX_IDLE)
    else $error("request-to-send not negated after drain");
  rts_both_off_a: assert property (st.mode1[UMFS_M1_RX_RTS] && st.tx == UMFS_TX_STOP // [R4]
    |=> st.tx != UMFS_TX_RTSD)
    else $error("automatic request-to-send not disabled");
  cts_wait_a: assert property (st.tx == UMFS_TX_IDLE && st.hold_full && st.mode2.tx_cts // [R5]
    && st.cts_n_s |=> st.tx == UMFS_TX_IDLE && st.tx_line)
    else $error("character sent while clear-to-send negated");
  cts_no_abort_a: assert property (st.tx == UMFS_TX_DATA && $changed(st.cts_n_s) // [R6]
    |-> st.tx != UMFS_TX_IDLE ##1 st.tx != UMFS_TX_IDLE)
    else $error("clear-to-send change disturbed a character");
  cts_governs_a: assert property (st.mode2.tx_cts && st.tx == UMFS_TX_STOP // [R7]
    |=> st.tx != UMFS_TX_RTSD)
    else $error("request-to-send control acted with gating on");
  stop_zero_a: assert property (!st.ext_clk && st.mode2.sb == 4'h0 // [R9]
    |-> stop_len == (five_bit ? 6'd17 : 6'd9))
    else $error("stop length for code zero is wrong");
  stop_top_a: assert property (!st.ext_clk && st.mode2.sb[2:0] == 3'h7 // [R10]
    |-> stop_len == (st.mode2.sb[3] ? 6'd32 : (five_bit ? 6'd24 : 6'd16)))
    else $error("stop length for top codes is wrong");
  stop_range_a: assert property (!st.ext_clk |-> stop_len >= (five_bit ? 6'd17 : 6'd9) // [R8]
    && stop_len <= 6'd32 && (st.mode2.sb != 4'h8 || stop_len == 6'd25))
    else $error("stop length out of range");
  rx_stop_a: assert property (st.rx == UMFS_RX_STOP && tick16 && st.rx_cnt == UMFS_RX_LAST // [R11]
    |=> st.rx_ready && st.rx_fe == !$past(rx_in))
    else $error("stop bit check wrong");
  ext_stop_a: assert property (st.ext_clk // [R12]
    |-> stop_len == {4'h0, st.mode2.sb[3], ~st.mode2.sb[3]})
    else $error("external clock stop count wrong");

  rts_dropped_c: cover property (st.tx == UMFS_TX_RTSD ##1 request_to_send_out_n_o);
  cts_held_c: cover property ((st.hold_full && st.mode2.tx_cts && st.cts_n_s) [*4]);
  frame_rx_c: cover property (st.rx == UMFS_RX_STOP ##1 st.rx_ready);
  echo_mode_c: cover property (st.mode2.cm == UMFS_CM_ECHO && !serial_transmit_line_o);

endmodule

// file: shared/umfs_pkg.sv
// Shared constants, types and the state record of the mode-two UART channel.
package umfs_pkg;

  // Register offsets on the plain register port.
  localparam logic [1:0] UMFS_ADDR_MODE   = 2'h0;
  localparam logic [1:0] UMFS_ADDR_STATUS = 2'h1;
  localparam logic [1:0] UMFS_ADDR_DATA   = 2'h2;
  localparam logic [1:0] UMFS_ADDR_CTRL   = 2'h3;

  // First mode register fields.
  localparam int UMFS_M1_RX_RTS = 7;
  localparam int UMFS_M1_PAR_EN = 2;

  // Control register bits.
  localparam int UMFS_CTRL_PTR_RST = 0;
  localparam int UMFS_CTRL_RTS_ON  = 1;
  localparam int UMFS_CTRL_RTS_OFF = 2;
  localparam int UMFS_CTRL_EXT_CLK = 3;

  // Status register bits.
  localparam int UMFS_ST_TX_RDY  = 0;
  localparam int UMFS_ST_TX_EMP  = 1;
  localparam int UMFS_ST_RX_RDY  = 2;
  localparam int UMFS_ST_FE      = 3;
  localparam int UMFS_ST_RTS     = 4;
  localparam int UMFS_ST_PTR     = 5;

  localparam logic [7:0] UMFS_MODE1_RST = 8'h00;
  localparam logic [7:0] UMFS_MODE2_RST = 8'h00;

  // Bit timing in sixteenths of a bit, except the external 1x clock values (whole bits), the minimum data bit count and the tick divider (system cycles).
  localparam logic [5:0] UMFS_BIT_SIXTEENTHS = 6'h10;
  localparam logic [5:0] UMFS_STOP_BASE_LONG = 6'h11;
  localparam logic [5:0] UMFS_STOP_BASE_SHRT = 6'h09;
  localparam logic [5:0] UMFS_EXT_STOP_ONE   = 6'h01;
  localparam logic [5:0] UMFS_EXT_STOP_TWO   = 6'h02;
  localparam logic [5:0] UMFS_EXT_BIT_LEN    = 6'h01;
  localparam logic [3:0] UMFS_RX_HALF        = 4'h7;
  localparam logic [3:0] UMFS_RX_LAST        = 4'hf;
  localparam logic [3:0] UMFS_MIN_BITS       = 4'h5;
  localparam logic [7:0] UMFS_TICK_DIV_DEF   = 8'h08;

  typedef enum logic [1:0] {
    UMFS_CM_NORMAL = 2'b00,
    UMFS_CM_ECHO   = 2'b01,
    UMFS_CM_LOCAL  = 2'b10,
    UMFS_CM_REMOTE = 2'b11
  } umfs_cm_t;

  typedef enum logic [2:0] {
    UMFS_TX_IDLE  = 3'b000,
    UMFS_TX_START = 3'b001,
    UMFS_TX_DATA  = 3'b010,
    UMFS_TX_PAR   = 3'b011,
    UMFS_TX_STOP  = 3'b100,
    UMFS_TX_RTSD  = 3'b101
  } umfs_tx_t;

  typedef enum logic [1:0] {
    UMFS_RX_IDLE  = 2'b00,
    UMFS_RX_START = 2'b01,
    UMFS_RX_BITS  = 2'b10,
    UMFS_RX_STOP  = 2'b11
  } umfs_rx_t;

  typedef struct packed {
    umfs_cm_t   cm;
    logic       tx_rts;
    logic       tx_cts;
    logic [3:0] sb;
  } umfs_mode2_t;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } umfs_bus_req_t;

  typedef struct packed {
    logic        ptr_mode2;
    logic [7:0]  mode1;
    umfs_mode2_t mode2;
    logic        ext_clk;
    logic        rxd_m;
    logic        rxd_s;
    logic        cts_m;
    logic        cts_n_s;
    logic        xclk_m;
    logic        xclk_s;
    logic        xclk_d;
    logic [7:0]  div;
    logic [7:0]  hold;
    logic        hold_full;
    umfs_tx_t    tx;
    logic [7:0]  tx_shift;
    logic [5:0]  tx_cnt;
    logic [3:0]  tx_idx;
    logic        tx_line;
    logic        serial;
    logic        rts_n;
    umfs_rx_t    rx;
    logic [3:0]  rx_cnt;
    logic [3:0]  rx_idx;
    logic [7:0]  rx_shift;
    logic [7:0]  rx_data;
    logic        rx_ready;
    logic        rx_fe;
    logic [7:0]  rdata;
  } umfs_state_t;

endpackage

// file: tb/umfs_serial_peer.sv
// Serial peer model: decodes transmitted frames and sends frames on the receive pin.
`timescale 1ns/1ns
module umfs_serial_peer (
  input  logic clk_i,
  input  logic line_i,
  input  int   bit_cyc_i,
  input  int   nbits_i,
  output logic rxd_o
);
  int         cyc;
  int         start_q[$];
  logic [7:0] byte_q[$];
  logic       stop_q[$];
  logic [7:0] sh;

  initial
  begin
    cyc = 0;
    rxd_o = 1'b1;
  end

  always @(posedge clk_i)
    cyc <= cyc + 1;

  // Samples each bit at its centre, least significant bit first.
  initial
  begin
    forever
    begin
      @(negedge line_i);
      start_q.push_back(cyc);
      sh = 8'h00;
      repeat (bit_cyc_i / 2) @(posedge clk_i);
      for (int i = 0; i < nbits_i; i++)
      begin
        repeat (bit_cyc_i) @(posedge clk_i);
        sh[i] = line_i;
      end
      repeat (bit_cyc_i) @(posedge clk_i);
      byte_q.push_back(sh);
      stop_q.push_back(line_i);
      wait (line_i === 1'b1);
    end
  end

  // One stop bit of the given level, then one idle bit; the pin idles high.
  task automatic send(input logic [7:0] d, input int n, input logic stop);
    rxd_o <= 1'b0;
    repeat (bit_cyc_i) @(posedge clk_i);
    for (int i = 0; i < n; i++)
    begin
      rxd_o <= d[i];
      repeat (bit_cyc_i) @(posedge clk_i);
    end
    rxd_o <= stop;
    repeat (bit_cyc_i) @(posedge clk_i);
    rxd_o <= 1'b1;
    repeat (bit_cyc_i) @(posedge clk_i);
  endtask
endmodule

// file: tb/testbench.sv
// Self-checking bench of the mode-two UART channel against a serial peer model.
`timescale 1ns/1ns
module testbench;
  import umfs_pkg::*;
  logic          clk_sys_i;
  logic          reset_n_i;
  umfs_bus_req_t bus_i;
  logic [7:0]    rdata_o;
  logic          rxd;
  logic          cts_n;
  logic          ext_clk;
  logic          ext_on;
  logic          line;
  logic          rts_n;
  int            fails;
  int            samples_checked;
  int            bitc;
  int            nbits;
  int            ov0;
  int            g;
  int            k;
  logic [7:0]    exp_q[$];
  logic [7:0]    d;
  logic [7:0]    d2;

  initial
  begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  // External 1x clock of 40 system cycles, phase unrelated to the system clock.
  initial
  begin
    ext_clk = 1'b0;
    #7;
    forever
    begin
      #1000;
      if (ext_on)
        ext_clk = ~ext_clk;
    end
  end

  umfs_top #(.TICK_DIV(8'h01)) dut (
    .clk_sys_i               (clk_sys_i),
    .reset_n_i               (reset_n_i),
    .bus_i                   (bus_i),
    .rdata_o                 (rdata_o),
    .rxd_i                   (rxd),
    .clear_to_send_in_n_i    (cts_n),
    .tx_ext_clk_i            (ext_clk),
    .serial_transmit_line_o  (line),
    .request_to_send_out_n_o (rts_n)
  );

  umfs_serial_peer peer (
    .clk_i     (clk_sys_i),
    .line_i    (line),
    .bit_cyc_i (bitc),
    .nbits_i   (nbits),
    .rxd_o     (rxd)
  );

  task automatic test_done();
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] want, input string msg);
    samples_checked++;
    if (got !== want)
    begin
      $display("wrong value at %0t ns: %s", $time, msg);
      fails++;
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    bus_i <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_i);
    bus_i <= '0;
    @(posedge clk_sys_i);
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_i);
    bus_i <= '0;
    #1;
    v = rdata_o;
    @(posedge clk_sys_i);
  endtask

  task automatic setmode(input logic [7:0] m1, input logic [7:0] m2);
    wr(UMFS_ADDR_CTRL, 8'h01);
    wr(UMFS_ADDR_MODE, m1);
    wr(UMFS_ADDR_MODE, m2);
    nbits = 5 + int'(m1[1:0]);
  endtask

  task automatic waitst(input int b, input logic v);
    int n;
    n = 0;
    rd(UMFS_ADDR_STATUS, d);
    while (d[b] !== v)
    begin
      n++;
      if (n > 3000)
      begin
        $display("wrong value at %0t ns: status wait timed out", $time);
        fails++;
        test_done();
      end
      rd(UMFS_ADDR_STATUS, d);
    end
  endtask

  task automatic tx2(input logic [7:0] a, input logic [7:0] b);
    peer.start_q.delete();
    wr(UMFS_ADDR_DATA, a);
    waitst(UMFS_ST_TX_RDY, 1'b1);
    wr(UMFS_ADDR_DATA, b);
    waitst(UMFS_ST_TX_EMP, 1'b1);
    repeat (2 * bitc) @(posedge clk_sys_i);
    exp_q.push_back(a & (8'hff >> (8 - nbits)));
    exp_q.push_back(b & (8'hff >> (8 - nbits)));
  endtask

  task automatic drain();
    chk(peer.byte_q.size(), exp_q.size(), "frame count");
    while (exp_q.size() > 0 && peer.byte_q.size() > 0)
    begin
      chk(peer.byte_q.pop_front(), exp_q.pop_front(), "frame data");
      chk(peer.stop_q.pop_front(), 1, "stop level");
    end
    exp_q.delete();
  endtask

  initial
  begin
    bus_i = '0;
    reset_n_i = 1'b0;
    cts_n = 1'b0;
    ext_on = 1'b0;
    bitc = 16;
    nbits = 5;
    // Back-to-back characters under the internal clock are parted by one idle cycle.
    ov0 = 1;
    fails = 0;
    samples_checked = 0;
    void'($urandom(32'h9359b93d));
    repeat (8) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    wr(UMFS_ADDR_CTRL, 8'h01);
    rd(UMFS_ADDR_MODE, d);
    chk(d, UMFS_MODE1_RST, "mode one reset value");
    rd(UMFS_ADDR_MODE, d);
    chk(d, UMFS_MODE2_RST, "mode two reset value");
    rd(UMFS_ADDR_STATUS, d);
    chk(d[UMFS_ST_PTR], 1, "pointer after first access");
    d2 = 8'($urandom);
    wr(UMFS_ADDR_MODE, d2);
    rd(UMFS_ADDR_MODE, d);
    chk(d, d2, "mode two read back");
    wr(UMFS_ADDR_CTRL, 8'h01);
    wr(UMFS_ADDR_MODE, 8'h03);
    rd(UMFS_ADDR_MODE, d);
    chk(d, d2, "pointer moved by first write");
    wr(UMFS_ADDR_CTRL, 8'h01);
    rd(UMFS_ADDR_MODE, d);
    chk(d, 8'h03, "first register via pointer");
    for (int n = 5; n <= 8; n += 3)
    begin
      for (int c = 0; c < 16; c++)
      begin
        setmode(8'(n - 5), 8'(c));
        tx2(8'($urandom), 8'($urandom));
        g = peer.start_q[1] - peer.start_q[0] - (1 + n) * 16;
        g = g - ((c >= 8 || n == 5) ? 17 + c : 9 + c);
        chk(g, ov0, "stop length");
        drain();
      end
    end
    bitc = 40;
    ext_on <= 1'b1;
    for (int c = 0; c < 16; c += 8)
    begin
      setmode(8'h00, 8'(c));
      wr(UMFS_ADDR_CTRL, 8'h08);
      tx2(8'($urandom), 8'($urandom));
      g = peer.start_q[1] - peer.start_q[0] - 40 * (6 + ((c >= 8) ? 2 : 1));
      chk(g > -8 && g < 8, 1, "external clock stop bits");
      drain();
    end
    ext_on <= 1'b0;
    bitc = 16;
    cts_n <= 1'b1;
    setmode(8'h00, 8'h30);
    wr(UMFS_ADDR_CTRL, 8'h02);
    peer.start_q.delete();
    d2 = 8'($urandom) & 8'h1f;
    wr(UMFS_ADDR_DATA, d2);
    exp_q.push_back(d2);
    repeat (300) @(posedge clk_sys_i);
    chk(peer.start_q.size(), 0, "character held back");
    chk(line, 1, "line high while held");
    cts_n <= 1'b0;
    repeat (40) @(posedge clk_sys_i);
    cts_n <= 1'b1;
    waitst(UMFS_ST_TX_EMP, 1'b1);
    repeat (40) @(posedge clk_sys_i);
    drain();
    chk(rts_n, 0, "gating governs transmitter");
    cts_n <= 1'b0;
    setmode(8'h00, 8'h20);
    wr(UMFS_ADDR_CTRL, 8'h04);
    chk(rts_n, 1, "request negated by software");
    wr(UMFS_ADDR_CTRL, 8'h02);
    chk(rts_n, 0, "request asserted");
    peer.start_q.delete();
    d2 = 8'($urandom) & 8'h1f;
    wr(UMFS_ADDR_DATA, d2);
    exp_q.push_back(d2);
    k = 0;
    while (rts_n !== 1'b1 && k < 1000)
    begin
      @(posedge clk_sys_i);
      k++;
    end
    if (k >= 1000)
    begin
      $display("wrong value at %0t ns: negation wait timed out", $time);
      fails++;
      test_done();
    end
    g = peer.cyc - peer.start_q[0] - (6 * 16 + 17 + 16);
    chk(g >= -2 && g <= ov0 + 3, 1, "automatic negation time");
    drain();
    setmode(8'h80, 8'h20);
    wr(UMFS_ADDR_CTRL, 8'h02);
    tx2(8'($urandom), 8'($urandom));
    repeat (40) @(posedge clk_sys_i);
    chk(rts_n, 0, "negation off for both");
    drain();
    setmode(8'h04, 8'h80);
    peer.start_q.delete();
    d2 = 8'($urandom) & 8'h1f;
    wr(UMFS_ADDR_DATA, d2);
    waitst(UMFS_ST_RX_RDY, 1'b1);
    chk(peer.start_q.size(), 0, "line quiet in local loop");
    rd(UMFS_ADDR_DATA, d);
    chk(d, d2, "local loop data");
    for (int m = 1; m <= 3; m += 2)
    begin
      setmode(8'h00, 8'(m << 6));
      d2 = 8'($urandom) & 8'h1f;
      peer.send(d2, 5, 1'b1);
      exp_q.push_back(d2);
      repeat (40) @(posedge clk_sys_i);
      drain();
      rd(UMFS_ADDR_STATUS, d);
      chk(d[UMFS_ST_RX_RDY], (m == 1) ? 1 : 0, "receiver in echo modes");
      rd(UMFS_ADDR_DATA, d);
    end
    for (int s = 0; s < 2; s++)
    begin
      setmode(8'h00, 8'h0f);
      d2 = 8'($urandom) & 8'h1f;
      peer.send(d2, 5, 1'(s));
      rd(UMFS_ADDR_STATUS, d);
      chk(d[UMFS_ST_FE], 1 - s, "stop centre check");
      rd(UMFS_ADDR_DATA, d);
      chk(d, d2, "received data");
    end
    test_done();
  end
endmodule
